// ===== include/scd_pkg.sv
// Purpose: Shared constants and carriers for the serial command decoder
// Assumes: 16-bit command frames, most significant bit first
// Notes: Identification values are supplied from outside the block
package scd_pkg;
  localparam int FRAME_BITS = 16;
  localparam int SYNC_STAGES = 3;
  localparam logic [4:0] LAST_RX_CNT = 5'h0F;
  localparam logic [4:0] HEAD_DONE_CNT = 5'h08;
  localparam logic [4:0] SUB_ADDR_CNT = 5'h09;
  localparam logic [4:0] FRAME_DONE_CNT = 5'h10;
  localparam logic [1:0] CMD_READ = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_RESERVED = 2'h2;
  localparam logic [1:0] CMD_FLAGS = 2'h3;
  localparam logic [4:0] ADDR_MONITOR = 5'h00;
  localparam logic [7:0] MONITOR_RESET = 8'h00;
  localparam logic [7:0] MONITOR_WR_MASK = 8'hF8;
  localparam int MON_SRC_MSB = 7;
  localparam int MON_SRC_LSB = 5;
  localparam int MON_RES_BIT = 4;
  localparam int MON_ATT_BIT = 3;
  localparam logic [2:0] MON_SRC_OFF = 3'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef struct packed {
    logic [1:0] kind;
    logic [4:0] addr;
    logic par;
    logic [7:0] data;
  } scd_cmd_t;

  typedef struct packed {
    logic [7:0] fixed_status;
    logic [7:0] ext_status;
    logic [7:0] id_io;
    logic [7:0] flags_lo;
    logic [7:0] flags_hi;
    logic [7:0] monitor;
  } scd_snap_t;

  // Expected bit 8: zero when the other fifteen bits hold an odd count of ones
  function automatic logic parity_of(input scd_cmd_t c);
    parity_of = ~(^{c.kind, c.addr, c.data});
  endfunction

  function automatic logic [7:0] reply_lo(input logic [1:0] kind, input logic [4:0] addr,
                                          input logic sub, input scd_snap_t s);
    unique case (kind)
      CMD_READ: reply_lo = sub ? s.id_io : ((addr == ADDR_MONITOR) ? s.monitor : BYTE_ZERO);
      CMD_WRITE: reply_lo = s.ext_status;
      CMD_FLAGS: reply_lo = sub ? s.flags_hi : s.flags_lo;
      CMD_RESERVED: reply_lo = BYTE_ZERO;
    endcase
  endfunction
endpackage

// ===== design/scd_sync.sv
// Purpose: Three-stage level synchroniser with agreement filter
// Assumes: Input is a slowly changing level or toggle
// Notes: Output follows only when the second and third stages agree
`timescale 1ns/1ns
`default_nettype none
module scd_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic d_i,
  output logic q_o
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_o <= 1'b0;
    end else if (s2 == s3) begin
      q_o <= s3;
    end
  end
endmodule // scd_sync
`default_nettype wire

// ===== design/scd_top.sv
// Purpose: Serial command decoder with analog monitor selection register
// Assumes: Serial clock idles low, data sampled on rising, shifted on falling edge
`timescale 1ns/1ns
`default_nettype none
module scd_top
  import scd_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic spi_clk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_n_o,
  input wire logic parity_en_i,
  input wire logic can_supply_on_i,
  input wire logic normal_mode_i,
  input wire logic [7:0] fixed_status_i,
  input wire logic [7:0] ext_status_i,
  input wire logic [7:0] id_io_i,
  input wire logic [7:0] flags_lo_i,
  input wire logic [7:0] flags_hi_i,
  output logic [2:0] monitor_source_sel_o,
  output logic internal_sense_resistor_en_o,
  output logic io_atten_o,
  output logic monitor_drive_en_o,
  output logic cmd_valid_o,
  output logic parity_err_o
);
  // Link side, serial clock domain
  logic [4:0] bit_cnt;
  logic [14:0] rx;
  scd_cmd_t cmd_word;
  logic cmd_tgl;
  scd_snap_t snap_link;
  logic snap_ack;
  logic snap_req_link;
  logic [15:0] tx;
  // Core side
  scd_snap_t snap_core;
  logic snap_req;
  logic snap_ack_core;
  logic cmd_tgl_core;
  logic cmd_seen;
  logic new_cmd;
  logic [7:0] monitor;
  logic wr_hit;
  logic par_ok;
  logic supply_ok;

  // Chip select clears framing so an aborted frame never misaligns the next
  always_ff @(posedge spi_clk_i or posedge spi_cs_n_i or posedge reset_i) begin
    if (spi_cs_n_i || reset_i) begin
      bit_cnt <= 5'h00;
    end else begin
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  always_ff @(posedge spi_clk_i) begin
    rx <= {rx[13:0], spi_mosi_i};
  end

  // Completed frame held stable while the toggle crosses over
  always_ff @(posedge spi_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cmd_word <= '0;
      cmd_tgl <= 1'b0;
    end else if (!spi_cs_n_i && bit_cnt == LAST_RX_CNT) begin
      cmd_word <= {rx, spi_mosi_i};
      cmd_tgl <= ~cmd_tgl;
    end
  end

  // Snapshot only moves while the serial clock runs; replies may trail by a frame
  always_ff @(posedge spi_clk_i or posedge reset_i) begin
    if (reset_i) begin
      snap_link <= '0;
      snap_ack <= 1'b0;
    end else if (snap_req_link != snap_ack) begin
      snap_link <= snap_core;
      snap_ack <= snap_req_link;
    end
  end

  // Reply bit 7 must leave before payload bit 7 arrives, so it follows the low sub-address
  always_ff @(negedge spi_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx <= 16'h0000;
    end else if (bit_cnt == FRAME_DONE_CNT) begin
      tx <= {snap_link.fixed_status, BYTE_ZERO};
    end else if (bit_cnt == HEAD_DONE_CNT) begin
      tx <= {reply_lo(rx[7:6], rx[5:1], 1'b0, snap_link), BYTE_ZERO};
    end else if (bit_cnt == SUB_ADDR_CNT) begin
      tx <= {reply_lo(rx[8:7], rx[6:2], rx[0], snap_link), BYTE_ZERO} << 1;
    end else begin
      tx <= {tx[14:0], 1'b0};
    end
  end

  assign spi_miso_o = tx[15];
  assign spi_miso_oe_n_o = spi_cs_n_i;

  scd_sync u_sync_req (
    .clk_i(spi_clk_i),
    .rst_i(reset_i),
    .d_i(snap_req),
    .q_o(snap_req_link)
  );

  scd_sync u_sync_ack (
    .clk_i(clk_i),
    .rst_i(reset_i),
    .d_i(snap_ack),
    .q_o(snap_ack_core)
  );

  scd_sync u_sync_cmd (
    .clk_i(clk_i),
    .rst_i(reset_i),
    .d_i(cmd_tgl),
    .q_o(cmd_tgl_core)
  );

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      snap_core <= '0;
      snap_req <= 1'b0;
    end else if (snap_ack_core == snap_req) begin
      snap_core <= {fixed_status_i, ext_status_i, id_io_i, flags_lo_i, flags_hi_i, monitor};
      snap_req <= ~snap_req;
    end
  end

  assign new_cmd = cmd_tgl_core != cmd_seen;
  assign supply_ok = can_supply_on_i && normal_mode_i;
  assign par_ok = !parity_en_i || (cmd_word.par == parity_of(cmd_word));
  assign wr_hit = new_cmd && cmd_word.kind == CMD_WRITE && cmd_word.addr == ADDR_MONITOR;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cmd_seen <= 1'b0;
    end else begin
      cmd_seen <= cmd_tgl_core;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i || !supply_ok) begin
      monitor <= MONITOR_RESET;
    end else if (wr_hit && par_ok) begin
      monitor <= cmd_word.data & MONITOR_WR_MASK;
    end
  end

  // Analog path decodes codes 001 and 010 from these selects
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      monitor_source_sel_o <= MON_SRC_OFF;
      internal_sense_resistor_en_o <= 1'b0;
      io_atten_o <= 1'b0;
      monitor_drive_en_o <= 1'b0;
    end else begin
      monitor_source_sel_o <= monitor[MON_SRC_MSB:MON_SRC_LSB];
      internal_sense_resistor_en_o <= monitor[MON_RES_BIT];
      io_atten_o <= monitor[MON_ATT_BIT];
      monitor_drive_en_o <= monitor[MON_SRC_MSB:MON_SRC_LSB] != MON_SRC_OFF;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cmd_valid_o <= 1'b0;
      parity_err_o <= 1'b0;
    end else begin
      cmd_valid_o <= new_cmd;
      parity_err_o <= new_cmd && cmd_word.kind == CMD_WRITE && !par_ok;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_good_write;
    wr_hit && par_ok && supply_ok;
  endsequence

  property p_write_lands;
    s_good_write |=> monitor == ($past(cmd_word.data) & MONITOR_WR_MASK);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("monitor write lost");

  property p_low_bits_zero;
    monitor[2:0] == 3'h0;
  endproperty
  a_low_bits_zero: assert property (p_low_bits_zero) else $error("fixed bits set");

  property p_clear_off;
    !supply_ok |=> monitor == MONITOR_RESET;
  endproperty
  a_clear_off: assert property (p_clear_off) else $error("monitor not cleared");

  property p_reserved_quiet;
    (new_cmd && cmd_word.kind == CMD_RESERVED && supply_ok) |=> $stable(monitor);
  endproperty
  a_reserved_quiet: assert property (p_reserved_quiet) else $error("reserved changed reg");

  property p_bad_parity;
    (wr_hit && parity_en_i && cmd_word.par != parity_of(cmd_word) && supply_ok)
      |=> $stable(monitor) && parity_err_o;
  endproperty
  a_bad_parity: assert property (p_bad_parity) else $error("bad parity written");

  property p_parity_off;
    (wr_hit && !parity_en_i && supply_ok) |=> !parity_err_o;
  endproperty
  a_parity_off: assert property (p_parity_off) else $error("parity flagged when off");

  property p_drive_off;
    monitor[MON_SRC_MSB:MON_SRC_LSB] == MON_SRC_OFF |=> !monitor_drive_en_o;
  endproperty
  a_drive_off: assert property (p_drive_off) else $error("monitor drives when off");

  property p_valid_pulse;
    new_cmd |=> cmd_valid_o ##1 !cmd_valid_o;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("command pulse wrong");

  property p_supply_ignore;
    (wr_hit && !can_supply_on_i) |=> (monitor == MONITOR_RESET) [*2];
  endproperty
  a_supply_ignore: assert property (p_supply_ignore) else $error("write taken supply off");
endmodule // scd_top
`default_nettype wire

// ===== bench/scd_host_model.sv
// Purpose: Host-side serial master model for the command decoder
// Assumes: Serial clock idles low, 6 ns period, stopped between frames
// Notes: Released data line shows the inverse of its last bit
`timescale 1ns/1ns
`default_nettype none
module scd_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  task automatic send(input logic [1:0] k, input logic [4:0] a, input logic [7:0] d,
                      input logic par_on, input logic bad, output logic [15:0] rsp);
    logic [15:0] cmd;
    cmd = {k, a, 1'b0, d};
    if (par_on) begin
      cmd[8] = ~(^{k, a, d}) ^ bad;
    end
    cs_n_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi_o = cmd[i];
      #3 sclk_o = 1'b1;
      rsp[i] = miso_i;
      #3 sclk_o = 1'b0;
    end
    #3 cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    // Long gap so the frame toggle crosses before the next one
    #80;
  endtask
endmodule // scd_host_model
`default_nettype wire

// ===== bench/sbc_spi_command_decoder_test.sv
// Purpose: Self-checking bench for the serial command decoder
// Assumes: Status inputs held steady, so stale snapshots still match
// Notes: Reply bit 7 of the low byte is compared only when payload bit 7 is zero
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module sbc_spi_command_decoder_test;
  import scd_pkg::*;
  // Reset starts low so its rise is a real edge for the async link flops
  logic clk_i = 1'b1;
  logic reset_i = 1'b0;
  logic sclk, cs_n, mosi, miso, miso_oe_n, res, att, drv, valid, perr;
  logic par_en = 1'b0;
  logic supply = 1'b1;
  logic normal = 1'b1;
  logic [7:0] fixed = 8'hA5;
  logic [7:0] ext = 8'h3C;
  logic [7:0] idio = 8'h5A;
  logic [7:0] flo = 8'h11;
  logic [7:0] fhi = 8'h66;
  logic [2:0] sel;
  logic [15:0] rsp;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  int n_perr = 0;
  int n_valid = 0;
  int nframes = 0;

  scd_host_model i_host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));
  scd_top i_dut (.clk_i(clk_i), .reset_i(reset_i), .spi_clk_i(sclk), .spi_cs_n_i(cs_n),
    .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_n_o(miso_oe_n),
    .parity_en_i(par_en), .can_supply_on_i(supply), .normal_mode_i(normal),
    .fixed_status_i(fixed), .ext_status_i(ext), .id_io_i(idio), .flags_lo_i(flo),
    .flags_hi_i(fhi), .monitor_source_sel_o(sel), .internal_sense_resistor_en_o(res),
    .io_atten_o(att), .monitor_drive_en_o(drv), .cmd_valid_o(valid), .parity_err_o(perr));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Select can rise on a rising clock edge when frames run back to back, so this check can race
  always @(posedge clk_i) begin
    `CHK("miso enable", cs_n, miso_oe_n)
  end

  // Hang guard, well above the thousand or so cycles the run needs
  always @(negedge clk_i) begin
    cycles++;
    if (perr === 1'b1) n_perr++;
    if (valid === 1'b1) n_valid++;
    if (cycles == 20000) begin
      n_errors++;
      conclude();
    end
  end

  task automatic frame(input logic [1:0] k, input logic [4:0] a, input logic [7:0] d,
                       input logic bad, input logic [7:0] lo);
    i_host.send(k, a, d, par_en, bad, rsp);
    nframes++;
    `CHK("status byte", fixed, rsp[15:8])
    `CHK("reply low", lo[6:0], rsp[6:0])
    // Reply bit 7 is chosen before payload bit 7 arrives
    if (!d[7]) begin
      `CHK("reply bit 7", lo[7], rsp[7])
    end
  endtask

  task automatic mon(input logic [7:0] v);
    @(negedge clk_i);
    `CHK("monitor", {v[7:3], 3'h0}, {sel, res, att, 3'h0})
    `CHK("drive", |v[7:5], drv)
    `CHK("miso idle", 1'b1, miso_oe_n)
  endtask

  task automatic set_lv(input logic p, input logic s, input logic nm);
    @(negedge clk_i);
    par_en = p;
    supply = s;
    normal = nm;
    repeat (12) @(negedge clk_i);
  endtask

  initial begin
    @(negedge clk_i);
    reset_i = 1'b1;
    repeat (3) @(negedge clk_i);
    reset_i = 1'b0;
    repeat (8) @(negedge clk_i);
    i_host.send(CMD_READ, ADDR_MONITOR, 8'h00, 1'b0, 1'b0, rsp);
    nframes++;
    mon(8'h00);
    frame(CMD_WRITE, ADDR_MONITOR, 8'hAF, 1'b0, 8'h3C);
    mon(8'hA8);
    i_host.send(CMD_READ, ADDR_MONITOR, 8'h00, 1'b0, 1'b0, rsp);
    nframes++;
    frame(CMD_READ, ADDR_MONITOR, 8'h00, 1'b0, 8'hA8);
    frame(CMD_READ, 5'h05, 8'h00, 1'b0, 8'h00);
    frame(CMD_READ, ADDR_MONITOR, 8'h80, 1'b0, 8'h5A);
    for (int s = 0; s < 2; s++) begin
      frame(CMD_FLAGS, 5'h12, {s[0], 7'h00}, 1'b0, s[0] ? fhi : flo);
    end
    frame(CMD_RESERVED, ADDR_MONITOR, 8'h20, 1'b0, 8'h00);
    mon(8'hA8);
    set_lv(1'b1, 1'b1, 1'b1);
    frame(CMD_WRITE, ADDR_MONITOR, 8'h30, 1'b1, 8'h3C);
    mon(8'hA8);
    frame(CMD_WRITE, ADDR_MONITOR, 8'h30, 1'b0, 8'h3C);
    mon(8'h30);
    frame(CMD_WRITE, ADDR_MONITOR, 8'h57, 1'b0, 8'h3C);
    mon(8'h50);
    set_lv(1'b0, 1'b1, 1'b1);
    frame(CMD_WRITE, ADDR_MONITOR, 8'h00, 1'b0, 8'h3C);
    mon(8'h00);
    frame(CMD_WRITE, ADDR_MONITOR, 8'hE0, 1'b0, 8'h3C);
    mon(8'hE0);
    set_lv(1'b0, 1'b0, 1'b1);
    mon(8'h00);
    frame(CMD_WRITE, ADDR_MONITOR, 8'hE0, 1'b0, 8'h3C);
    mon(8'h00);
    set_lv(1'b0, 1'b1, 1'b1);
    frame(CMD_WRITE, ADDR_MONITOR, 8'h68, 1'b0, 8'h3C);
    mon(8'h68);
    set_lv(1'b0, 1'b1, 1'b0);
    mon(8'h00);
    frame(CMD_WRITE, ADDR_MONITOR, 8'h68, 1'b0, 8'h3C);
    mon(8'h00);
    repeat (10) @(negedge clk_i);
    `CHK("frames seen", nframes, n_valid)
    `CHK("parity errors", 1, n_perr)
    conclude();
  end
endmodule // sbc_spi_command_decoder_test
`default_nettype wire
